// [logic/boot_cmd_pkg.sv]
// Constants and types shared by the boot serial command handler files
`default_nettype none
package boot_cmd_pkg;
   // ****************************************************************
   // Command, response and error codes
   // ****************************************************************
   localparam logic [7:0] CMD_CLK_MODE = 8'h11;
   localparam logic [7:0] CMD_ERASE = 8'h58;
   localparam logic [7:0] CMD_MEM_READ = 8'h52;
   localparam logic [7:0] RSP_ACK = 8'h06;
   localparam logic [7:0] RSP_CLK_ERR = 8'h91;
   localparam logic [7:0] RSP_ERASE_ERR = 8'hD8;
   localparam logic [7:0] RSP_READ_ERR = 8'hD2;
   localparam logic [7:0] RSP_CMD_ERR = 8'h80;
   localparam logic [7:0] ERR_CHECKSUM = 8'h11;
   localparam logic [7:0] ERR_CLK_MODE = 8'h22;
   localparam logic [7:0] ERR_ADDRESS = 8'h2A;
   localparam logic [7:0] ERR_COMMAND = 8'h30;
   // ****************************************************************
   // Field values and layout
   // ****************************************************************
   localparam logic [7:0] ERASE_STOP_CODE = 8'hFF;
   localparam logic [7:0] ERASE_SIZE = 8'h01;
   localparam logic [7:0] READ_SIZE = 8'h09;
   localparam logic [7:0] AREA_USER_BOOT = 8'h00;
   localparam logic [7:0] AREA_USER_PROG = 8'h01;
   localparam logic [7:0] CLK_MODE_RESET = 8'h00;
   localparam int PAYLOAD_BITS = 72;
   localparam int TX_HDR_BITS = 40;
   // ****************************************************************
   // Handler states
   // ****************************************************************
   typedef enum logic [7:0]
   {
      ST_IDLE = 8'h01,
      ST_SIZE = 8'h02,
      ST_PAYLOAD = 8'h04,
      ST_SUM = 8'h08,
      ST_EXEC = 8'h10,
      ST_TX = 8'h20,
      ST_MEMRD = 8'h40,
      ST_TXSUM = 8'h80
   } state_t;
endpackage : boot_cmd_pkg
`default_nettype wire

// [logic/byte_buf_if.sv]
// Valid/ready byte channel between the handler and its reply buffer
`timescale 1ns/10ps
`default_nettype none
interface byte_buf_if;
   logic in_valid;
   logic [7:0] in_data;
   logic in_ready;
   logic out_valid;
   logic [7:0] out_data;
   logic out_ready;
   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface : byte_buf_if
`default_nettype wire

// [logic/byte_buffer.sv]
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_buffer
(
   input wire logic i_clk,      // System clock
   input wire logic i_reset_n,  // Synchronous reset, active low
   byte_buf_if.fifo bus         // Fill and drain sides
);
   logic [7:0] e0_q, e0_d, e1_q, e1_d;
   logic [1:0] count_q, count_d;
   logic push, pop;

   // Handshakes; ready drops only when both entries are taken
   assign bus.in_ready = (count_q != 2'h2);
   assign bus.out_valid = (count_q != 2'h0);
   assign bus.out_data = e0_q;
   assign push = bus.in_valid & bus.in_ready;
   assign pop = bus.out_valid & bus.out_ready;

   // Next entries; head is always e0 so the output is a flop
   always_comb
   begin
      e0_d = e0_q;
      e1_d = e1_q;
      count_d = count_q;
      case ({push, pop})
         2'b10:
         begin
            if (count_q == 2'h0) e0_d = bus.in_data;
            else e1_d = bus.in_data;
            count_d = count_q + 2'h1;
         end
         2'b01:
         begin
            e0_d = e1_q;
            count_d = count_q - 2'h1;
         end
         2'b11:
         begin
            if (count_q == 2'h1) e0_d = bus.in_data;
            else
            begin
               e0_d = e1_q;
               e1_d = bus.in_data;
            end
         end
         default: count_d = count_q;
      endcase
   end

   // Registers
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         e0_q <= 8'h00;
         e1_q <= 8'h00;
         count_q <= 2'h0;
      end
      else
      begin
         e0_q <= e0_d;
         e1_q <= e1_d;
         count_q <= count_d;
      end
   end
endmodule : byte_buffer
`default_nettype wire

// [logic/boot_serial_command_handler.sv]
// Boot serial command handler: clock mode, erase stop and memory read
`timescale 1ns/10ps
`default_nettype none
module boot_serial_command_handler
(
   input wire logic I_MCLK,               // System clock, 100 MHz
   input wire logic I_RESET_N,            // Synchronous reset, low
   input wire logic [7:0] I_RX_DATA,      // Received host byte
   input wire logic I_RX_VALID,           // Received byte present
   output logic O_RX_READY,               // Handler takes a byte
   output logic [7:0] O_TX_DATA,          // Reply byte to host
   output logic O_TX_VALID,               // Reply byte present
   input wire logic I_TX_READY,           // Transmitter takes byte
   input wire logic [7:0] I_MODE_COUNT,   // Number of clock modes
   output logic [7:0] O_CLK_MODE,         // Selected clock mode
   output logic O_CLK_MODE_SET,           // Clock mode applied
   output logic [7:0] O_ERASE_BLOCK,      // Block to erase
   output logic O_ERASE_REQ,              // Erase one block
   output logic O_ERASE_STOP,             // Erasure sequence ended
   output logic O_MEM_REQ,                // Memory byte request
   output logic O_MEM_AREA,               // 0 boot area, 1 program
   output logic [31:0] O_MEM_ADDR,        // Memory byte address
   input wire logic I_MEM_ACK,            // Memory byte returned
   input wire logic [7:0] I_MEM_DATA      // Memory byte
);
   import boot_cmd_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   state_t state_q, state_d;
   logic [7:0] cmd_q, cmd_d, size_q, size_d, cnt_q, cnt_d;
   logic [7:0] sum_q, sum_d, txsum_q, txsum_d;
   logic [PAYLOAD_BITS-1:0] pl_q, pl_d;
   logic [TX_HDR_BITS-1:0] tx_sh_q, tx_sh_d;
   logic [2:0] tx_n_q, tx_n_d;
   logic [31:0] rd_left_q, rd_left_d, addr_q, addr_d;
   logic rd_en_q, rd_en_d, area_q, area_d;
   logic [7:0] clk_mode_q, clk_mode_d, blk_q, blk_d;
   logic mode_set_q, mode_set_d, erase_q, erase_d, stop_q, stop_d;
   logic rx_take, push, sum_ok;
   logic [7:0] rx_sum, mode_b, area_b;
   logic [31:0] addr_b, rsize_b;
   byte_buf_if txb ();

   // ****************************************************************
   // Reply buffer
   // ****************************************************************
   // A stalled transmitter only holds the handler, no byte is dropped
   byte_buffer u_reply_buf
   (
      .i_clk (I_MCLK),
      .i_reset_n (I_RESET_N),
      .bus (txb.fifo)
   );
   assign O_TX_DATA = txb.out_data;
   assign O_TX_VALID = txb.out_valid;
   assign txb.out_ready = I_TX_READY;

   // Receive handshake and frame field views
   assign O_RX_READY = (state_q == ST_IDLE) || (state_q == ST_SIZE) ||
                       (state_q == ST_PAYLOAD) || (state_q == ST_SUM);
   assign rx_take = O_RX_READY & I_RX_VALID;
   assign rx_sum = sum_q + I_RX_DATA;
   assign sum_ok = (sum_q == 8'h00);
   assign mode_b = pl_q[7:0];
   assign area_b = pl_q[71:64];
   assign addr_b = pl_q[63:32];
   assign rsize_b = pl_q[31:0];

   // Reply byte source: header shifter, memory data or closing sum
   always_comb
   begin
      txb.in_valid = 1'b0;
      txb.in_data = tx_sh_q[39:32];
      O_MEM_REQ = 1'b0;
      case (state_q)
         ST_TX: txb.in_valid = 1'b1;
         ST_MEMRD:
         begin
            // Ask only with room, so the returned byte always fits
            O_MEM_REQ = txb.in_ready;
            txb.in_valid = I_MEM_ACK;
            txb.in_data = I_MEM_DATA;
         end
         ST_TXSUM:
         begin
            txb.in_valid = 1'b1;
            txb.in_data = 8'h00 - txsum_q;
         end
         default: txb.in_valid = 1'b0;
      endcase
   end
   assign push = txb.in_valid & txb.in_ready;

   // ****************************************************************
   // Frame sequencer
   // ****************************************************************
   // Next state of the whole command and reply sequence
   always_comb
   begin
      state_d = state_q;
      cmd_d = cmd_q;
      size_d = size_q;
      cnt_d = cnt_q;
      sum_d = sum_q;
      txsum_d = txsum_q;
      pl_d = pl_q;
      tx_sh_d = tx_sh_q;
      tx_n_d = tx_n_q;
      rd_left_d = rd_left_q;
      addr_d = addr_q;
      rd_en_d = rd_en_q;
      area_d = area_q;
      clk_mode_d = clk_mode_q;
      blk_d = blk_q;
      mode_set_d = 1'b0;
      erase_d = 1'b0;
      stop_d = 1'b0;
      case (state_q)
         ST_IDLE:
            if (rx_take)
            begin
               cmd_d = I_RX_DATA;
               sum_d = I_RX_DATA;
               rd_en_d = 1'b0;
               state_d = ST_SIZE;
            end
         ST_SIZE:
            if (rx_take)
            begin
               size_d = I_RX_DATA;
               cnt_d = I_RX_DATA;
               sum_d = rx_sum;
               state_d = (I_RX_DATA == 8'h00) ? ST_SUM : ST_PAYLOAD;
            end
         ST_PAYLOAD:
            if (rx_take)
            begin
               // Last nine bytes kept; fields are read from fixed spots
               pl_d = {pl_q[PAYLOAD_BITS-9:0], I_RX_DATA};
               sum_d = rx_sum;
               cnt_d = cnt_q - 8'h01;
               if (cnt_q == 8'h01) state_d = ST_SUM;
            end
         ST_SUM:
            if (rx_take)
            begin
               sum_d = rx_sum;
               state_d = ST_EXEC;
            end
         ST_EXEC:
         begin
            state_d = ST_TX;
            txsum_d = 8'h00;
            tx_n_d = 3'h2;
            tx_sh_d = {RSP_CMD_ERR, ERR_COMMAND, 24'h000000};
            case (cmd_q)
               CMD_CLK_MODE:
                  if (!sum_ok)
                     tx_sh_d = {RSP_CLK_ERR, ERR_CHECKSUM, 24'h000000};
                  else if (mode_b < I_MODE_COUNT)
                  begin
                     clk_mode_d = mode_b;
                     mode_set_d = 1'b1;
                     tx_n_d = 3'h1;
                     tx_sh_d = {RSP_ACK, 32'h00000000};
                  end
                  else
                     tx_sh_d = {RSP_CLK_ERR, ERR_CLK_MODE, 24'h000000};
               CMD_ERASE:
                  if (!sum_ok || size_q != ERASE_SIZE)
                     tx_sh_d = {RSP_ERASE_ERR, ERR_CHECKSUM, 24'h000000};
                  else
                  begin
                     stop_d = (mode_b == ERASE_STOP_CODE);
                     erase_d = (mode_b != ERASE_STOP_CODE);
                     blk_d = mode_b;
                     tx_n_d = 3'h1;
                     tx_sh_d = {RSP_ACK, 32'h00000000};
                  end
               CMD_MEM_READ:
                  if (!sum_ok || size_q != READ_SIZE)
                     tx_sh_d = {RSP_READ_ERR, ERR_CHECKSUM, 24'h000000};
                  else if (area_b != AREA_USER_BOOT &&
                           area_b != AREA_USER_PROG)
                     tx_sh_d = {RSP_READ_ERR, ERR_ADDRESS, 24'h000000};
                  else
                  begin
                     area_d = (area_b == AREA_USER_PROG);
                     addr_d = addr_b;
                     rd_left_d = rsize_b;
                     rd_en_d = 1'b1;
                     tx_n_d = 3'h5;
                     tx_sh_d = {CMD_MEM_READ, rsize_b};
                  end
               default: tx_n_d = 3'h2;
            endcase
         end
         ST_TX:
            if (push)
            begin
               txsum_d = txsum_q + tx_sh_q[39:32];
               tx_sh_d = {tx_sh_q[31:0], 8'h00};
               tx_n_d = tx_n_q - 3'h1;
               if (tx_n_q == 3'h1)
               begin
                  if (!rd_en_q) state_d = ST_IDLE;
                  else if (rd_left_q == 32'h00000000) state_d = ST_TXSUM;
                  else state_d = ST_MEMRD;
               end
            end
         ST_MEMRD:
            if (push)
            begin
               txsum_d = txsum_q + I_MEM_DATA;
               addr_d = addr_q + 32'h00000001;
               rd_left_d = rd_left_q - 32'h00000001;
               if (rd_left_q == 32'h00000001) state_d = ST_TXSUM;
            end
         ST_TXSUM:
            if (push) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // Registers of the sequencer
   always_ff @(posedge I_MCLK)
   begin
      if (!I_RESET_N)
      begin
         state_q <= ST_IDLE;
         cmd_q <= 8'h00;
         size_q <= 8'h00;
         cnt_q <= 8'h00;
         sum_q <= 8'h00;
         txsum_q <= 8'h00;
         pl_q <= '0;
         tx_sh_q <= '0;
         tx_n_q <= 3'h0;
         rd_left_q <= 32'h00000000;
         addr_q <= 32'h00000000;
         rd_en_q <= 1'b0;
         area_q <= 1'b0;
         clk_mode_q <= CLK_MODE_RESET;
         blk_q <= 8'h00;
         mode_set_q <= 1'b0;
         erase_q <= 1'b0;
         stop_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         size_q <= size_d;
         cnt_q <= cnt_d;
         sum_q <= sum_d;
         txsum_q <= txsum_d;
         pl_q <= pl_d;
         tx_sh_q <= tx_sh_d;
         tx_n_q <= tx_n_d;
         rd_left_q <= rd_left_d;
         addr_q <= addr_d;
         rd_en_q <= rd_en_d;
         area_q <= area_d;
         clk_mode_q <= clk_mode_d;
         blk_q <= blk_d;
         mode_set_q <= mode_set_d;
         erase_q <= erase_d;
         stop_q <= stop_d;
      end
   end

   // Registered outputs
   assign O_CLK_MODE = clk_mode_q;
   assign O_CLK_MODE_SET = mode_set_q;
   assign O_ERASE_BLOCK = blk_q;
   assign O_ERASE_REQ = erase_q;
   assign O_ERASE_STOP = stop_q;
   assign O_MEM_AREA = area_q;
   assign O_MEM_ADDR = addr_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESET_N);
   logic exec_clk, exec_erase, exec_read;
   assign exec_clk = (state_q == ST_EXEC) && (cmd_q == CMD_CLK_MODE);
   assign exec_erase = (state_q == ST_EXEC) && (cmd_q == CMD_ERASE);
   assign exec_read = (state_q == ST_EXEC) && (cmd_q == CMD_MEM_READ);

   chk_clk_apply: assert property (exec_clk && sum_ok &&
      mode_b < I_MODE_COUNT |=> mode_set_q && clk_mode_q == $past(mode_b))
      else $error("clock mode not applied");
   chk_clk_ack: assert property (mode_set_q |-> state_q == ST_TX &&
      tx_n_q == 3'h1 && tx_sh_q[39:32] == RSP_ACK ##1 O_TX_VALID)
      else $error("clock mode ack missing");
   chk_clk_sum_err: assert property (exec_clk && !sum_ok |=>
      tx_n_q == 3'h2 && tx_sh_q[39:24] == {RSP_CLK_ERR, ERR_CHECKSUM})
      else $error("clock checksum error reply wrong");
   chk_clk_mode_err: assert property (exec_clk && sum_ok &&
      mode_b >= I_MODE_COUNT |=> !mode_set_q &&
      tx_sh_q[39:24] == {RSP_CLK_ERR, ERR_CLK_MODE})
      else $error("clock mode error reply wrong");
   chk_erase_stop: assert property (exec_erase && sum_ok &&
      size_q == ERASE_SIZE && mode_b == ERASE_STOP_CODE |=>
      O_ERASE_STOP && !O_ERASE_REQ)
      else $error("stop code not seen");
   chk_erase_ack: assert property (O_ERASE_STOP |->
      tx_sh_q[39:32] == RSP_ACK ##[0:3] (push && txb.in_data == RSP_ACK))
      else $error("erase stop ack missing");
   chk_area_err: assert property (exec_read && sum_ok &&
      size_q == READ_SIZE && area_b > AREA_USER_PROG |=>
      !rd_en_q && tx_sh_q[39:24] == {RSP_READ_ERR, ERR_ADDRESS})
      else $error("area error reply wrong");
   chk_read_head: assert property (exec_read ##1 rd_en_q |->
      tx_n_q == 3'h5 && tx_sh_q == {CMD_MEM_READ, $past(rsize_b)} &&
      rd_left_q == $past(rsize_b))
      else $error("read reply header wrong");
   chk_read_close: assert property (state_q == ST_MEMRD && push &&
      rd_left_q == 32'h00000001 |=> state_q == ST_TXSUM)
      else $error("read reply not closed by checksum");
   chk_rx_sum: assert property (state_q == ST_SUM && rx_take |=>
      sum_q == $past(rx_sum) && state_q == ST_EXEC)
      else $error("frame sum not accumulated");

   cov_clk_ack: cover property (mode_set_q);
   cov_erase_stop: cover property (O_ERASE_STOP);
   cov_read_done: cover property (state_q == ST_TXSUM && push);
   cov_area_err: cover property (exec_read && sum_ok &&
      area_b > AREA_USER_PROG);
endmodule : boot_serial_command_handler
`default_nettype wire

// [verif/boot_host_model.sv]
// Host and memory stand-in facing the boot command handler
`timescale 1ns/10ps
`default_nettype none
module boot_host_model
(
   input wire logic i_clk,             // System clock
   output logic [7:0] o_rx_data,       // Byte to handler
   output logic o_rx_valid,            // Byte offered
   input wire logic i_rx_ready,        // Handler takes byte
   input wire logic [7:0] i_tx_data,   // Reply byte
   input wire logic i_tx_valid,        // Reply offered
   output logic o_tx_ready,            // Host takes reply
   input wire logic i_mem_req,         // Memory byte wanted
   input wire logic [31:0] i_mem_addr, // Memory byte address
   output logic o_mem_ack,             // Memory byte returned
   output logic [7:0] o_mem_data,      // Memory byte
   input wire logic i_slow             // Stall replies and memory
);
   int wait_q;
   // ****************************************************************
   // Host side
   // ****************************************************************
   // Idle lines show the inverted last byte so stale data never matches
   initial
   begin
      o_rx_data = 8'h00;
      o_rx_valid = 1'b0;
      o_tx_ready = 1'b0;
      o_mem_ack = 1'b0;
      o_mem_data = 8'h00;
      wait_q = 0;
   end
   // Offer a byte and hold it until the edge that takes it
   task automatic put_byte(input logic [7:0] b, output bit ok);
      int n;
      ok = 0;
      @(negedge i_clk);
      o_rx_data = b;
      o_rx_valid = 1'b1;
      for (n = 0; n < 200 && !ok; n++)
      begin
         @(posedge i_clk);
         ok = (i_rx_ready === 1'b1);
      end
   endtask : put_byte
   // Release the receive line after a frame
   task automatic idle();
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data;
   endtask : idle
   // Take one reply byte, stalling first when slow so the buffer fills
   task automatic get_byte(output logic [7:0] b, output bit ok);
      int n;
      ok = 0;
      b = 8'h00;
      @(negedge i_clk);
      if (i_slow)
         repeat (4) @(negedge i_clk);
      o_tx_ready = 1'b1;
      for (n = 0; n < 300 && !ok; n++)
      begin
         @(posedge i_clk);
         if (i_tx_valid === 1'b1)
         begin
            b = i_tx_data;
            ok = 1;
         end
      end
      @(negedge i_clk);
      o_tx_ready = 1'b0;
   endtask : get_byte
   // ****************************************************************
   // Memory side
   // ****************************************************************
   // Data is the address low byte scrambled, so order errors show
   always @(negedge i_clk)
   begin
      o_mem_ack <= 1'b0;
      o_mem_data <= ~o_mem_data;
      if (i_mem_req === 1'b1 && !o_mem_ack)
      begin
         wait_q <= wait_q + 1;
         if (wait_q >= (i_slow ? 3 : 0))
         begin
            wait_q <= 0;
            o_mem_ack <= 1'b1;
            o_mem_data <= i_mem_addr[7:0] ^ 8'hA5;
         end
      end
   end
endmodule : boot_host_model
`default_nettype wire

// [verif/tb_boot_serial_command_handler.sv]
// Self-checking bench for the boot serial command handler
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
$display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
module tb_boot_serial_command_handler;
   import boot_cmd_pkg::*;
   typedef logic [7:0] byte_q_t[$];
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] rx_data, tx_data, mode_count = 8'h02, clk_mode, erase_blk;
   logic [7:0] mem_data;
   logic rx_valid, rx_ready, tx_valid, tx_ready, mode_set, erase_req;
   logic erase_stop, mem_req, mem_area, mem_ack, slow = 1'b0;
   logic [31:0] mem_addr;
   int fails = 0;
   int checks_done = 0;
   int n_set = 0;
   int n_req = 0;
   int n_stop = 0;
   // ****************************************************************
   // Clock, instances and pulse counters
   // ****************************************************************
   always #5 clk = ~clk;
   boot_serial_command_handler DUT (.I_MCLK(clk), .I_RESET_N(rst_n),
      .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready),
      .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready),
      .I_MODE_COUNT(mode_count), .O_CLK_MODE(clk_mode),
      .O_CLK_MODE_SET(mode_set), .O_ERASE_BLOCK(erase_blk),
      .O_ERASE_REQ(erase_req), .O_ERASE_STOP(erase_stop),
      .O_MEM_REQ(mem_req), .O_MEM_AREA(mem_area), .O_MEM_ADDR(mem_addr),
      .I_MEM_ACK(mem_ack), .I_MEM_DATA(mem_data));
   boot_host_model host (.i_clk(clk), .o_rx_data(rx_data),
      .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_mem_req(mem_req),
      .i_mem_addr(mem_addr), .o_mem_ack(mem_ack), .o_mem_data(mem_data),
      .i_slow(slow));
   // Pulses are counted, since they stand for a single cycle only
   always @(posedge clk)
   begin
      if (rst_n)
      begin
         n_set += (mode_set === 1'b1);
         n_req += (erase_req === 1'b1);
         n_stop += (erase_stop === 1'b1);
      end
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // Send a frame with its checksum (plus a bump to spoil it), then
   // collect and compare the whole reply
   task automatic exchange(input byte_q_t cmd, input byte_q_t exp,
      input int bump);
      logic [7:0] b;
      logic [7:0] s;
      bit ok;
      s = 8'h00;
      foreach (cmd[i])
      begin
         s += cmd[i];
         host.put_byte(cmd[i], ok);
         if (!ok) begin fails++; report_and_stop(); end
      end
      host.put_byte(8'h00 - s + bump[7:0], ok);
      if (!ok) begin fails++; report_and_stop(); end
      host.idle();
      foreach (exp[i])
      begin
         host.get_byte(b, ok);
         if (!ok) begin fails++; report_and_stop(); end
         `CHK(b, exp[i])
      end
   endtask : exchange
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_clock();
      for (int m = 0; m < 2; m++)
      begin
         exchange('{CMD_CLK_MODE, 8'h01, m[7:0]}, '{RSP_ACK}, 0);
         `CHK(clk_mode, m[7:0])
      end
      `CHK(n_set, 2)
      exchange('{CMD_CLK_MODE, 8'h01, 8'h02}, '{8'h91, 8'h22}, 0);
      exchange('{CMD_CLK_MODE, 8'h01, 8'h00}, '{8'h91, 8'h11}, 1);
      `CHK(clk_mode, 8'h01)
      @(negedge clk);
      mode_count = 8'h03;
      exchange('{CMD_CLK_MODE, 8'h01, 8'h02}, '{8'h06}, 0);
      `CHK(clk_mode, 8'h02)
      $display("test clock done");
   endtask : t_clock
   task automatic t_erase();
      exchange('{CMD_ERASE, 8'h01, 8'h03}, '{RSP_ACK}, 0);
      `CHK(erase_blk, 8'h03)
      exchange('{CMD_ERASE, 8'h01, 8'hFF}, '{8'h06}, 0);
      `CHK(n_stop, 1)
      `CHK(n_req, 1)
      // Size 2 means two payload bytes, so the frame stays well formed
      exchange('{CMD_ERASE, 8'h02, 8'h03, 8'h00}, '{8'hD8, 8'h11}, 0);
      exchange('{CMD_ERASE, 8'h01, 8'h07}, '{8'h06}, 0);
      `CHK(n_req, 2)
      $display("test erase done");
   endtask : t_erase
   task automatic t_read();
      byte_q_t exp;
      logic [7:0] s;
      exp = '{8'h52, 8'h00, 8'h00, 8'h00, 8'h03};
      for (int i = 0; i < 3; i++)
         exp.push_back((8'hFE + i[7:0]) ^ 8'hA5);
      s = 8'h00;
      foreach (exp[i])
         s += exp[i];
      exp.push_back(8'h00 - s);
      @(negedge clk);
      slow = 1'b1;
      exchange('{8'h52, 8'h09, 8'h00, 8'h00, 8'h00, 8'h10, 8'hFE,
         8'h00, 8'h00, 8'h00, 8'h03}, exp, 0);
      `CHK(mem_addr, 32'h0000_1101)
      `CHK(mem_area, 1'b0)
      `CHK(mem_req, 1'b0)
      @(negedge clk);
      slow = 1'b0;
      exchange('{8'h52, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00}, '{8'h52, 8'h00, 8'h00, 8'h00,
         8'h00, 8'hAE}, 0);
      `CHK(mem_area, 1'b1)
      exchange('{8'h52, 8'h09, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h01}, '{RSP_READ_ERR, 8'h2A}, 0);
      exchange('{8'h52, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h01}, '{8'hD2, 8'h11}, 8'h01);
      $display("test read done");
   endtask : t_read
   // Unknown command with an empty payload gets the command error reply
   task automatic t_unknown();
      exchange('{8'h33, 8'h00}, '{RSP_CMD_ERR, ERR_COMMAND}, 0);
      `CHK(rx_ready, 1'b1)
      $display("test unknown done");
   endtask : t_unknown
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      `CHK(tx_valid, 1'b0)
      // Device selection lies outside this block; clock selection opens
      t_clock();
      t_erase();
      t_read();
      t_unknown();
      report_and_stop();
   end
endmodule : tb_boot_serial_command_handler
`default_nettype wire
